// File: tcte_timer.sv
// 16-bit trigger/event/window/pulse-capture timer
// assumes all inputs synchronous to clk; compare value written as two bytes

`include "tcte_consts.svh"

module tcte_timer #(
	parameter int CNT_W    = `TCTE_CNT_W,
	parameter int REJECT   = `TCTE_REJECT_CYC,
	parameter int PRESC_W  = `TCTE_PRESC_W
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire tcte_pkg::tcte_ctrl_t timer_control_reg,
	input  wire logic [7:0]           compare_wdata,
	input  wire logic                 compare_wr_low,
	input  wire logic                 compare_wr_high,
	input  wire logic                 timer_input_pin,
	output logic [CNT_W-1:0]          capture_value_reg,
	output logic [CNT_W-1:0]          compare_value_reg,
	output logic [CNT_W-1:0]          count_value,
	output logic                      timer_interrupt_request
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************
	// input filter and edges
	// ****************
	// pin level accepted only after it has been steady longer than the reject time
	localparam int FW = $clog2(REJECT + 2);
	logic [FW-1:0] flt_cnt;
	logic          flt_raw;
	logic          flt_level;
	logic          pin_q;
	logic          pin_prev;
	wire           flt_differs = (timer_input_pin != flt_level);
	wire           flt_done    = (flt_cnt == FW'(REJECT));

	always_ff @(posedge clk) begin
		if (rst) begin
			flt_cnt   <= '0;
			flt_level <= 1'b0;
		end else if (!flt_differs) begin
			flt_cnt   <= '0;
		end else if (flt_done) begin
			flt_level <= timer_input_pin;
			flt_cnt   <= '0;
		end else begin
			flt_cnt   <= flt_cnt + FW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flt_raw  <= 1'b0;
			pin_q    <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			flt_raw  <= flt_level;
			pin_q    <= flt_raw;
			pin_prev <= pin_q;
		end
	end

	wire rise_edge = pin_q & ~pin_prev;
	wire fall_edge = ~pin_q & pin_prev;

	// ****************
	// control decode
	// ****************
	wire [1:0] start_control = timer_control_reg.start_control;
	wire [1:0] mode          = timer_control_reg.operating_mode_select;
	wire       stopped       = (start_control == `TCTE_START_STOP);
	wire       falling_sel   = (start_control == `TCTE_START_FALL);
	wire       edge_start    = start_control[1];
	wire       trig_edge     = falling_sel ? fall_edge : rise_edge;
	wire       opp_edge      = falling_sel ? rise_edge : fall_edge;
	wire       mode_timer    = (mode == `TCTE_MODE_TIMER);
	wire       mode_window   = (mode == `TCTE_MODE_WINDOW);
	wire       mode_pulse    = (mode == `TCTE_MODE_PULSE);
	wire       ext_trig      = mode_timer & edge_start & (timer_control_reg.source_clock_select != `TCTE_SRC_PIN);
	wire       event_mode    = mode_timer & edge_start & (timer_control_reg.source_clock_select == `TCTE_SRC_PIN);
	wire       window_level  = falling_sel ? ~pin_q : pin_q;

	// ****************
	// prescaler
	// ****************
	logic [PRESC_W-1:0] presc;
	logic               presc_prev_bit;

	function automatic int tap_index(input logic [1:0] sel, input logic dv);
		tap_index = (sel == `TCTE_SRC_DIV0) ? 10 : (sel == `TCTE_SRC_DIV1) ? 6 : 2;
		tap_index = tap_index + int'(dv);
	endfunction

	wire tap_bit = presc[tap_index(timer_control_reg.source_clock_select, timer_control_reg.prescaler_divide_select)];

	always_ff @(posedge clk) begin
		if (rst) begin
			presc          <= '0;
			presc_prev_bit <= 1'b0;
		end else begin
			presc          <= presc + PRESC_W'(1);
			presc_prev_bit <= tap_bit;
		end
	end

	wire int_tick = tap_bit & ~presc_prev_bit;
	// external source clock counts selected pin edges in edge-start timer mode only
	wire src_tick = event_mode ? trig_edge : int_tick;

	// ****************
	// compare staging
	// ****************
	logic [7:0] low_stage;
	logic [7:0] high_stage;
	logic       high_pending;

	always_ff @(posedge clk) begin
		if (rst) begin
			low_stage         <= 8'h00;
			high_stage        <= 8'h00;
			high_pending      <= 1'b0;
			compare_value_reg <= '0;
		end else begin
			if (compare_wr_low)
				low_stage <= compare_wdata;
			if (compare_wr_high) begin
				high_stage   <= compare_wdata;
				high_pending <= 1'b1;
			end else if (high_pending && (src_tick || stopped)) begin
				// low byte alone never reaches the active value
				compare_value_reg <= {high_stage, low_stage};
				high_pending      <= 1'b0;
			end
		end
	end

	// ****************
	// counter sequencer
	// ****************
	tcte_pkg::tcte_state_t state;
	tcte_pkg::tcte_state_t next_state;
	logic [CNT_W-1:0]      next_count;
	logic [CNT_W-1:0]      next_capture;
	logic                  next_irq;
	logic                  second_half;
	logic                  next_second_half;
	wire                   match = (count_value == compare_value_reg);

	always_comb begin
		next_state       = state;
		next_count       = count_value;
		next_capture     = capture_value_reg;
		next_irq         = 1'b0;
		next_second_half = second_half;
		if (stopped || mode == `TCTE_MODE_PPG) begin
			next_state       = tcte_pkg::TCTE_IDLE;
			next_count       = '0;
			next_second_half = 1'b0;
		end else if (mode_pulse) begin
			unique case (state)
				tcte_pkg::TCTE_IDLE, tcte_pkg::TCTE_HALT: begin
					if (trig_edge) begin
						next_state       = tcte_pkg::TCTE_RUN;
						next_second_half = 1'b0;
					end
				end
				tcte_pkg::TCTE_RUN: begin
					if (opp_edge && !second_half) begin
						next_capture = count_value;
						next_irq     = 1'b1;
						if (timer_control_reg.capture_edge_mode) begin
							// counter parks at one until the next trigger
							next_count = CNT_W'(1);
							next_state = tcte_pkg::TCTE_HALT;
						end else begin
							next_second_half = 1'b1;
						end
					end else if (trig_edge && second_half) begin
						next_capture     = count_value;
						next_irq         = 1'b1;
						next_count       = '0;
						next_second_half = 1'b0;
					end else if (int_tick) begin
						next_count = count_value + CNT_W'(1);
					end
				end
				default: next_state = tcte_pkg::TCTE_IDLE;
			endcase
		end else if (ext_trig) begin
			unique case (state)
				tcte_pkg::TCTE_IDLE, tcte_pkg::TCTE_HALT: begin
					if (trig_edge) begin
						next_state = tcte_pkg::TCTE_RUN;
						next_count = '0;
					end
				end
				tcte_pkg::TCTE_RUN: begin
					if (match) begin
						next_count = '0;
						next_irq   = 1'b1;
						next_state = tcte_pkg::TCTE_HALT;
					end else if (opp_edge && timer_control_reg.trigger_stop_option) begin
						next_count = '0;
						next_state = tcte_pkg::TCTE_HALT;
					end else if (int_tick) begin
						// new trigger edges ignored here
						next_count = count_value + CNT_W'(1);
					end
				end
				default: next_state = tcte_pkg::TCTE_IDLE;
			endcase
		end else begin
			next_state = tcte_pkg::TCTE_RUN;
			if (event_mode) begin
				if (opp_edge && match) begin
					next_count = '0;
					next_irq   = 1'b1;
				end else if (src_tick) begin
					next_count = count_value + CNT_W'(1);
				end
			end else if (mode_timer || (mode_window && window_level)) begin
				if (int_tick) begin
					if (match) begin
						next_count = '0;
						next_irq   = 1'b1;
					end else begin
						next_count = count_value + CNT_W'(1);
					end
				end
			end
			// pulse mode keeps captures to itself
			if (timer_control_reg.auto_capture_enable && src_tick)
				next_capture = count_value;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state                   <= tcte_pkg::TCTE_IDLE;
			count_value             <= '0;
			capture_value_reg       <= '0;
			timer_interrupt_request <= 1'b0;
			second_half             <= 1'b0;
		end else begin
			state                   <= next_state;
			count_value             <= next_count;
			capture_value_reg       <= next_capture;
			timer_interrupt_request <= next_irq;
			second_half             <= next_second_half;
		end
	end

endmodule

// File: tcte_consts.svh
// timing and field constants for the trigger/event capture timer
// assumes a 100 MHz system clock; included by the package and design
`ifndef TCTE_CONSTS_SVH
`define TCTE_CONSTS_SVH

// ****************
// widths and codes
// ****************
`define TCTE_CNT_W         16
`define TCTE_START_STOP    2'h0
`define TCTE_START_CMD     2'h1
`define TCTE_START_RISE    2'h2
`define TCTE_START_FALL    2'h3
`define TCTE_MODE_TIMER    2'h0
`define TCTE_MODE_WINDOW   2'h1
`define TCTE_MODE_PULSE    2'h2
`define TCTE_MODE_PPG      2'h3
`define TCTE_SRC_DIV0      2'h0
`define TCTE_SRC_DIV1      2'h1
`define TCTE_SRC_DIV2      2'h2
`define TCTE_SRC_PIN       2'h3

// ****************
// timing
// ****************
`define TCTE_CLK_MHZ       100
`define TCTE_REJECT_NS     40
`define TCTE_REJECT_CYC    ((`TCTE_REJECT_NS * `TCTE_CLK_MHZ + 999) / 1000)
`define TCTE_PRESC_W       13

`endif

// File: tcte_pkg.sv
// types shared by the trigger/event capture timer
// assumes tcte_consts.svh is on the include path
`include "tcte_consts.svh"

package tcte_pkg;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************
	// control bundle
	// ****************
	typedef struct packed {
		logic [1:0] start_control;
		logic [1:0] operating_mode_select;
		logic [1:0] source_clock_select;
		logic       prescaler_divide_select;
		logic       trigger_stop_option;
		logic       capture_edge_mode;
		logic       auto_capture_enable;
	} tcte_ctrl_t;

	typedef enum logic [2:0] {
		TCTE_IDLE = 3'b001,
		TCTE_RUN  = 3'b010,
		TCTE_HALT = 3'b100
	} tcte_state_t;

endpackage

// File: tcte_pin_src.sv
// pulse source driving the timer input pin
// assumes the bench calls hold() in sequence
module tcte_pin_src (
	input  wire logic clk,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin = 1'b0;
	// ****************
	// level driver
	// ****************
	// gating kept far slower than the source tick
	task automatic hold(input logic v, input int n);
		@(negedge clk) pin = v;
		repeat (n - 1) @(negedge clk);
	endtask
endmodule

// File: tcte_timer_sva.sv
// port assertions for the capture timer
// assumes synchronous active-high reset
`include "tcte_consts.svh"
module tcte_timer_sva #(
	parameter int CNT_W = 16
) (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire tcte_pkg::tcte_ctrl_t timer_control_reg,
	input wire logic [7:0]           compare_wdata,
	input wire logic                 compare_wr_low,
	input wire logic                 compare_wr_high,
	input wire logic                 timer_input_pin,
	input wire logic [CNT_W-1:0]     capture_value_reg,
	input wire logic [CNT_W-1:0]     compare_value_reg,
	input wire logic [CNT_W-1:0]     count_value,
	input wire logic                 timer_interrupt_request
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// helpers
	// ****************
	logic             armed;
	logic [CNT_W-1:0] prev_cmp;
	wire logic [1:0]  md = timer_control_reg.operating_mode_select;
	wire logic        irq = timer_interrupt_request;
	always_ff @(posedge clk) begin
		prev_cmp <= compare_value_reg;
		if (rst || compare_value_reg != prev_cmp)
			armed <= compare_wr_high;
		else if (compare_wr_high)
			armed <= 1'b1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ****************
	// checks
	// ****************
	reset_clear_a: assert property ($fell(rst) |-> count_value == '0 && compare_value_reg == '0 && !irq)
		else $error("outputs not clear after reset");
	stop_clear_a: assert property ((timer_control_reg.start_control == `TCTE_START_STOP) [*2] |-> count_value == '0)
		else $error("count not cleared by stop");
	irq_pulse_a: assert property (irq |=> !irq)
		else $error("interrupt longer than one cycle");
	cmp_load_a: assert property (compare_value_reg != prev_cmp |-> armed)
		else $error("compare loaded without high byte");
	ppg_idle_a: assert property ((md == `TCTE_MODE_PPG) [*3] |-> count_value == '0 && !irq)
		else $error("generator mode not idle");
	count_step_a: assert property (count_value != $past(count_value) |-> count_value <= 1 || count_value == $past(count_value) + 1)
		else $error("count jumped");
	match_clear_a: assert property (irq && md != `TCTE_MODE_PULSE |-> count_value == '0)
		else $error("match did not clear count");
	match_value_a: assert property (irq && md != `TCTE_MODE_PULSE |-> $past(count_value) == compare_value_reg || $past(count_value) + 1 == compare_value_reg)
		else $error("interrupt without match");
	single_rest_a: assert property (irq && md == `TCTE_MODE_PULSE && timer_control_reg.capture_edge_mode |-> count_value == 1)
		else $error("single capture not resting at one");
	cover property (irq && md == `TCTE_MODE_TIMER);
	cover property (irq && md == `TCTE_MODE_WINDOW);
	cover property (irq && md == `TCTE_MODE_PULSE);
endmodule
bind tcte_timer tcte_timer_sva #(.CNT_W(CNT_W)) u_sva (.clk(clk), .rst(rst), .timer_control_reg(timer_control_reg),
	.compare_wdata(compare_wdata), .compare_wr_low(compare_wr_low), .compare_wr_high(compare_wr_high),
	.timer_input_pin(timer_input_pin), .capture_value_reg(capture_value_reg), .compare_value_reg(compare_value_reg),
	.count_value(count_value), .timer_interrupt_request(timer_interrupt_request));

// File: testbench.sv
// self-checking bench for the capture timer
// assumes package, pin source and checker compiled first
`include "tcte_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clk, rst, wl, wh, pin, irq;
	logic [7:0]           wd;
	logic [15:0]          cap, cmp, cnt, v;
	tcte_pkg::tcte_ctrl_t ctrl;
	int                   failures, samples_checked, irqs, base, n;
	logic [31:0]          seed = 32'h0000_6db5;
	tcte_timer u_dut (.clk(clk), .rst(rst), .timer_control_reg(ctrl), .compare_wdata(wd), .compare_wr_low(wl),
		.compare_wr_high(wh), .timer_input_pin(pin), .capture_value_reg(cap), .compare_value_reg(cmp),
		.count_value(cnt), .timer_interrupt_request(irq));
	tcte_pin_src u_src (.clk(clk), .pin(pin));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (irq === 1'b1) irqs++;
	// ****************
	// helpers
	// ****************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// source tick is 8 clocks at divide code 10
	function automatic logic [15:0] ticks(input int cycles);
		return 16'(cycles / 8);
	endfunction
	task automatic check(input logic [15:0] seen, exp, input logic [15:0] tol = 16'h0000);
		samples_checked++;
		if (^seen === 1'bx || (seen > exp ? seen - exp : exp - seen) > tol) begin
			failures++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic irqs_since(input int k);
		check(16'(irqs - base), 16'(k));
		base = irqs;
	endtask
	// fields only change while stopped
	task automatic go(input logic [1:0] st, md, src, input logic [2:0] opt, input logic [15:0] c);
		@(negedge clk) ctrl = {`TCTE_START_STOP, md, src, 1'b0, opt};
		@(negedge clk) {wl, wd} = {1'b1, c[7:0]};
		@(negedge clk) {wl, wh, wd} = {2'b01, c[15:8]};
		@(negedge clk) wh = 1'b0;
		@(negedge clk) ctrl = {st, md, src, 1'b0, opt};
		base = irqs;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#500000;
		failures++;
		tally_and_finish();
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		{rst, wl, wh, wd, ctrl} = {1'b1, 20'h0_0000};
		repeat (3) @(negedge clk);
		rst = 1'b0;
		check(cnt | cap | cmp, 16'h0000);
		@(negedge clk) {wl, wd} = {1'b1, 8'ha5};
		@(negedge clk) wl = 1'b0;
		repeat (4) @(negedge clk);
		check(cmp, 16'h0000);
		v = 16'h0040 + 16'(rnd() & 32'h0000_00ff);
		go(`TCTE_START_STOP, `TCTE_MODE_TIMER, `TCTE_SRC_DIV2, 3'b000, v);
		check(cmp, v);
		go(`TCTE_START_RISE, `TCTE_MODE_TIMER, `TCTE_SRC_DIV2, 3'b100, 16'h0004);
		u_src.hold(1'b1, 100);
		irqs_since(1);
		check(cnt, 16'h0000);
		u_src.hold(1'b0, 20);
		u_src.hold(1'b1, 16);
		u_src.hold(1'b0, 60);
		irqs_since(0);
		check(cnt, 16'h0000);
		u_src.hold(1'b1, 80);
		irqs_since(1);
		u_src.hold(1'b0, 20);
		go(`TCTE_START_RISE, `TCTE_MODE_TIMER, `TCTE_SRC_DIV2, 3'b000, 16'h0008);
		u_src.hold(1'b1, 16);
		u_src.hold(1'b0, 16);
		u_src.hold(1'b1, 16);
		// short wait: a wrongly restarted count could not match yet
		u_src.hold(1'b0, 30);
		irqs_since(1);
		go(`TCTE_START_RISE, `TCTE_MODE_TIMER, `TCTE_SRC_PIN, 3'b000, 16'h0004);
		n = 1 + int'(rnd() % 3);
		for (int i = 0; i < 5; i++) begin
			u_src.hold(1'b1, 12);
			u_src.hold(1'b0, 12);
			if (i == n - 1) begin
				check(cnt, 16'(n));
				u_src.hold(1'b1, 1 + int'(rnd() % 4));
				u_src.hold(1'b0, 12);
				check(cnt, 16'(n));
			end
			if (i == 3) begin
				irqs_since(1);
				check(cnt, 16'h0000);
			end
		end
		check(cnt, 16'h0001);
		go(`TCTE_START_RISE, `TCTE_MODE_WINDOW, `TCTE_SRC_DIV2, 3'b000, v);
		u_src.hold(1'b0, 80);
		check(cnt, 16'h0000);
		u_src.hold(1'b1, 160);
		check(cnt, ticks(160), 16'h0002);
		go(`TCTE_START_FALL, `TCTE_MODE_WINDOW, `TCTE_SRC_DIV2, 3'b000, 16'h0004);
		u_src.hold(1'b0, 60);
		irqs_since(1);
		go(`TCTE_START_RISE, `TCTE_MODE_PULSE, `TCTE_SRC_DIV2, 3'b010, v);
		u_src.hold(1'b0, 20);
		u_src.hold(1'b1, 80);
		u_src.hold(1'b0, 40);
		irqs_since(1);
		check(cap, ticks(80), 16'h0002);
		check(cnt, 16'h0001);
		go(`TCTE_START_RISE, `TCTE_MODE_PULSE, `TCTE_SRC_DIV2, 3'b000, v);
		u_src.hold(1'b1, 80);
		u_src.hold(1'b0, 80);
		u_src.hold(1'b1, 40);
		irqs_since(2);
		check(cap, ticks(160), 16'h0002);
		go(`TCTE_START_CMD, `TCTE_MODE_PPG, `TCTE_SRC_DIV2, 3'b000, v);
		repeat (20) @(negedge clk);
		check(cnt, 16'h0000);
		go(`TCTE_START_CMD, `TCTE_MODE_TIMER, `TCTE_SRC_DIV2, 3'b001, v);
		repeat (100) @(negedge clk);
		check(cnt, ticks(100), 16'h0001);
		check(cap, ticks(100) - 16'h0001, 16'h0001);
		@(negedge clk) ctrl.start_control = `TCTE_START_STOP;
		repeat (2) @(negedge clk);
		check(cnt, 16'h0000);
		tally_and_finish();
	end
endmodule
